/* hdl/trf_pkg.sv */
/*
  Package for the thread register file: widths, indices, reset values,
  flag positions, register offsets and packed carriers.
  Assumes one 125 MHz core clock and a synchronous active-low reset.
*/
package trf_pkg;

  // ---------------------------------------------------------------
  // Sizes and indices
  // ---------------------------------------------------------------
  localparam int unsigned GPR_COUNT     = 63;
  localparam logic [5:0]  GPR_ZERO_IDX  = 6'h3f;
  localparam logic [2:0]  PRED_TRUE_IDX = 3'h7;
  localparam int unsigned PROG_TYPES    = 6;
  localparam logic [6:0]  GPR_LIMIT_RST = 7'h3f;
  localparam logic [6:0]  SREG_LANEID   = 7'h00;
  localparam logic [6:0]  SREG_TID      = 7'h20;
  localparam logic [6:0]  SREG_CTAID    = 7'h25;
  localparam logic [6:0]  SREG_CLOCK    = 7'h50;
  localparam logic [6:0]  SREG_CLOCKHI  = 7'h51;

  // ---------------------------------------------------------------
  // Condition code and flags view positions
  // ---------------------------------------------------------------
  localparam int unsigned CC_ZERO     = 0;
  localparam int unsigned CC_SIGN     = 1;
  localparam int unsigned CC_CARRY    = 2;
  localparam int unsigned CC_OVFL     = 3;
  localparam int unsigned FLAGS_PRED  = 0;
  localparam int unsigned FLAGS_CC    = 12;
  localparam logic [31:0] FLAGS_MASK  = 32'h0000f07f;

  // ---------------------------------------------------------------
  // AXI4-Lite register offsets (bytes)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_LIMIT0  = 8'h00;  // Six words, one per program type
  localparam logic [7:0]  REG_PTYPE   = 8'h18;  // Active program type
  localparam logic [7:0]  REG_STATUS  = 8'h1c;  // Flags view readback
  localparam logic [7:0]  REG_LANEID  = 8'h20;
  localparam logic [7:0]  REG_TID     = 8'h24;
  localparam logic [7:0]  REG_CTAID   = 8'h28;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TRF_W32, TRF_W64, TRF_W128} trf_width_t;

  typedef struct packed {
    logic        en;
    trf_width_t  width;
    logic [5:0]  idx;
    logic [127:0] data;
  } trf_gpr_wr_t;

  typedef struct packed {
    logic       valid;
    logic       is_float;
    logic       is_add;
    logic       carry;
    logic       ovfl;
    logic [31:0] result;
  } trf_cc_upd_t;

endpackage : trf_pkg

/* hdl/trf_cc_eval.sv */
/*
  Condition-code evaluator for one 32-bit result.
  Assumes the execution pipeline supplies carry and overflow of its adder.
*/
`timescale 1ns/1ps
module trf_cc_eval (
  input  trf_pkg::trf_cc_upd_t upd,
  output logic [3:0]           cc
);
  import trf_pkg::*;

  wire is_nan  = (upd.result[30:23] == 8'hff) && (upd.result[22:0] != 23'h0);
  wire f_zero  = (upd.result[30:0] == 31'h0);

  // Zero and sign differ for float results, carry/overflow only from adds
  assign cc[CC_ZERO]  = upd.is_float ? (f_zero | is_nan)
                                     : (upd.result == 32'h0);
  assign cc[CC_SIGN]  = upd.result[31] | (upd.is_float & is_nan);
  assign cc[CC_CARRY] = ~upd.is_float & upd.is_add & upd.carry;
  assign cc[CC_OVFL]  = ~upd.is_float & upd.is_add & upd.ovfl;

endmodule : trf_cc_eval

/* hdl/trf_top.sv */
/*
  Thread register file: 63 GPRs, zero register, grouped operands, seven
  predicates, condition code, flags view, special registers and an
  AXI4-Lite slave for the per-program-type register count.
  Assumes one clock aclk and synchronous active-low reset aresetn; the
  execution pipeline drives read indices and write requests.
*/
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
//Contract
// [RULE1] Each thread has sixty-three 32-bit general registers indexed 0 to 62.
// [RULE2] Register index 63 always reads as zero.
// [RULE3] A per-program-type count limits usable registers; those at or above it read zero.
// [RULE4] A 64-bit operand is an even register (low half) and the next one (high half).
// [RULE5] A 128-bit operand is four registers from a multiple of four, lowest index least.
// [RULE6] No operand selection addresses a 16-bit half of a register.
// [RULE7] Seven predicates 0 to 6 exist and predicate 7 always reads one.
// [RULE8] Condition bit 0 is zero: integer zero, or float zero or NaN.
// [RULE9] Condition bit 1 is sign: integer top bit, or float negative or NaN.
// [RULE10] Condition bit 2 is carry out of an integer add.
// [RULE11] Condition bit 3 is signed overflow of an integer add.
// [RULE12] The flags view puts predicates at bits 0-6 and condition code at 12-15.
// [RULE13] Read-only 32-bit special registers sit in an index space of 0 to 127.
// [RULE14] Writes to the zero register or the true predicate are discarded.
// [RULE15] Flags view bits outside those fields read zero and ignore writes.
module trf_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [7:0]            s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [31:0]                s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  // Operand read port
  input  wire logic [5:0]            rd_idx,
  input  wire trf_pkg::trf_width_t   rd_width,
  output logic [127:0]               rd_data,
  // Write port, predicate, condition code and flags
  input  wire trf_pkg::trf_gpr_wr_t  gpr_wr,
  input  wire logic                  pred_we,
  input  wire logic [2:0]            pred_idx,
  input  wire logic                  pred_wdata,
  input  wire logic [2:0]            pred_rd_idx,
  output logic                       pred_rd,
  input  wire trf_pkg::trf_cc_upd_t  cc_upd,
  output logic [3:0]                 cc_q_out,
  input  wire logic                  flags_we,
  input  wire logic [31:0]           flags_wdata,
  output logic [31:0]                flags_rd,
  // Special register read
  input  wire logic [6:0]            sreg_idx,
  input  wire logic [4:0]            lane_id,
  output logic [31:0]                sreg_rd
);
  import trf_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] gpr_q [GPR_COUNT];
  logic [6:0]  pred_q;
  logic [3:0]  cc_q;
  logic [6:0]  limit_q [PROG_TYPES];
  logic [2:0]  ptype_q;
  logic [31:0] tid_q;
  logic [31:0] ctaid_q;
  logic [63:0] clock_q;
  logic [3:0]  cc_new;

  trf_cc_eval u_cc (
    .upd (cc_upd),
    .cc  (cc_new)
  );

  // ---------------------------------------------------------------
  // GPR read with zero register, count limit and grouping
  // ---------------------------------------------------------------
  wire [6:0] limit_cur = (ptype_q < 3'(PROG_TYPES)) ? limit_q[ptype_q] : GPR_LIMIT_RST;
  wire [5:0] base_idx  = (rd_width == TRF_W128) ? {rd_idx[5:2], 2'b00} :  // see [RULE5]
                         (rd_width == TRF_W64)  ? {rd_idx[5:1], 1'b0}  :  // see [RULE4]
                                                   rd_idx;

  function automatic logic [31:0] gpr_word(input logic [5:0] i, input logic [31:0] v,
                                           input logic [6:0] lim);
    logic [31:0] w;
    w = 32'h0;
    if (i != GPR_ZERO_IDX && {1'b0, i} < lim)  // see [RULE2] see [RULE3]
      w = v;
    return w;
  endfunction : gpr_word

  // Only whole 32-bit words are ever selected, never a half; the stored word and
  // the limit are arguments so that a write or a new limit re-evaluates the read
  wire [31:0] w0 = gpr_word(base_idx, gpr_q[base_idx], limit_cur);  // see [RULE6]
  wire [31:0] w1 = gpr_word(base_idx | 6'h01, gpr_q[base_idx | 6'h01], limit_cur);
  wire [31:0] w2 = gpr_word(base_idx | 6'h02, gpr_q[base_idx | 6'h02], limit_cur);
  wire [31:0] w3 = gpr_word(base_idx | 6'h03, gpr_q[base_idx | 6'h03], limit_cur);
  wire [127:0] rd_next = (rd_width == TRF_W128) ? {w3, w2, w1, w0} :
                         (rd_width == TRF_W64)  ? {64'h0, w1, w0}  :
                                                  {96'h0, w0};

  // ---------------------------------------------------------------
  // GPR writes; the zero register never stores
  // ---------------------------------------------------------------
  wire [5:0] wr_base = (gpr_wr.width == TRF_W128) ? {gpr_wr.idx[5:2], 2'b00} :
                       (gpr_wr.width == TRF_W64)  ? {gpr_wr.idx[5:1], 1'b0}  :
                                                    gpr_wr.idx;
  wire [2:0] wr_words = (gpr_wr.width == TRF_W128) ? 3'd4 :
                        (gpr_wr.width == TRF_W64)  ? 3'd2 : 3'd1;

  always_ff @(posedge aclk) begin
    for (int i = 0; i < GPR_COUNT; i++) begin
      if (!aresetn) begin
        gpr_q[i] <= 32'h0;
      end else if (gpr_wr.en && i[5:0] >= wr_base &&  // see [RULE1] see [RULE14]
                   {1'b0, i[5:0]} < {1'b0, wr_base} + {4'h0, wr_words}) begin
        gpr_q[i] <= gpr_wr.data[32*2'(i[5:0] - wr_base) +: 32];  // Word k lands at base plus k
      end
    end
  end

  // ---------------------------------------------------------------
  // Predicates, condition code and the flags view
  // ---------------------------------------------------------------
  wire [6:0] pred_set = (pred_we && pred_idx != PRED_TRUE_IDX)     // see [RULE14]
                        ? (7'h01 << pred_idx) : 7'h00;
  wire [31:0] flags_view = {16'h0, cc_q, 5'h0, pred_q};             // see [RULE12] see [RULE15]

  // Flags restore first, result updates override; a single predicate write rebuilds all seven predicates from their old values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pred_q <= 7'h00;
      cc_q   <= 4'h0;
    end else begin
      if (flags_we) begin
        pred_q <= flags_wdata[FLAGS_PRED +: 7];                     // see [RULE12]
        cc_q   <= flags_wdata[FLAGS_CC +: 4];
      end
      if (pred_set != 7'h00)
        pred_q <= (pred_q & ~pred_set) | (pred_wdata ? pred_set : 7'h00);  // see [RULE7]
      if (cc_upd.valid)
        cc_q <= cc_new;                           // see [RULE8] see [RULE9] see [RULE10] see [RULE11]
    end
  end

  // ---------------------------------------------------------------
  // Special registers and clock counter
  // ---------------------------------------------------------------
  wire [31:0] sreg_next = (sreg_idx == SREG_LANEID)  ? {27'h0, lane_id} :   // see [RULE13]
                          (sreg_idx == SREG_TID)     ? tid_q :
                          (sreg_idx == SREG_CTAID)   ? ctaid_q :
                          (sreg_idx == SREG_CLOCK)   ? clock_q[31:0] :
                          (sreg_idx == SREG_CLOCKHI) ? clock_q[63:32] : 32'h0;

  // Registered read outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data  <= 128'h0;
      pred_rd  <= 1'b0;
      cc_q_out <= 4'h0;
      flags_rd <= 32'h0;
      sreg_rd  <= 32'h0;
      clock_q  <= 64'h0;
    end else begin
      rd_data  <= rd_next;
      pred_rd  <= (pred_rd_idx == PRED_TRUE_IDX) ? 1'b1 : pred_q[pred_rd_idx];  // see [RULE7]
      cc_q_out <= cc_q;
      flags_rd <= flags_view;
      sreg_rd  <= sreg_next;
      clock_q  <= clock_q + 64'h1;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic       aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  wire        aw_take  = s_awvalid && s_awready;
  wire        w_take   = s_wvalid && s_wready;
  wire        wr_go    = aw_held_q && w_held_q && !s_bvalid;
  wire        wr_limit = awaddr_q < REG_PTYPE && awaddr_q[1:0] == 2'b00;
  wire [2:0]  wr_sel   = 3'(awaddr_q[7:2]);
  wire        wr_ok    = wr_limit || awaddr_q == REG_PTYPE ||
                         awaddr_q == REG_TID || awaddr_q == REG_CTAID;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
      ptype_q   <= 3'h0;
      tid_q     <= 32'h0;
      ctaid_q   <= 32'h0;
      for (int i = 0; i < PROG_TYPES; i++) limit_q[i] <= GPR_LIMIT_RST;
    end else begin
      s_awready <= !aw_held_q && !aw_take;
      s_wready  <= !w_held_q && !w_take;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_wdata;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_limit && s_wstrb[0])
          limit_q[wr_sel] <= (wdata_q[6:0] > 7'(GPR_COUNT)) ? 7'(GPR_COUNT) : wdata_q[6:0];  // see [RULE3]
        if (awaddr_q == REG_PTYPE && s_wstrb[0])
          ptype_q <= wdata_q[2:0];
        if (awaddr_q == REG_TID)
          tid_q <= wdata_q;
        if (awaddr_q == REG_CTAID)
          ctaid_q <= wdata_q;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  wire        ar_take = s_arvalid && s_arready;
  wire [2:0]  rd_sel  = 3'(s_araddr[7:2]);
  wire        rd_lim  = s_araddr < REG_PTYPE && s_araddr[1:0] == 2'b00;
  wire        rd_hit  = rd_lim || s_araddr == REG_PTYPE || s_araddr == REG_STATUS ||
                        s_araddr == REG_LANEID || s_araddr == REG_TID ||
                        s_araddr == REG_CTAID;
  wire [31:0] rd_word = rd_lim                  ? {25'h0, limit_q[rd_sel]} :
                        (s_araddr == REG_PTYPE)  ? {29'h0, ptype_q} :
                        (s_araddr == REG_STATUS) ? flags_view :
                        (s_araddr == REG_LANEID) ? {27'h0, lane_id} :
                        (s_araddr == REG_TID)    ? tid_q :
                        (s_araddr == REG_CTAID)  ? ctaid_q : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !ar_take;
      if (ar_take) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_word;
        s_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence zero_read_s;
    rd_width == TRF_W32 && rd_idx == GPR_ZERO_IDX;
  endsequence

  zero_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)   // see [RULE2]
    zero_read_s |=> rd_data == 128'h0) else $error("zero register read nonzero");
  true_pred_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE7]
    pred_rd_idx == PRED_TRUE_IDX |=> pred_rd) else $error("true predicate read zero");
  limit_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE3]
    rd_width == TRF_W32 && {1'b0, rd_idx} >= limit_cur |=> rd_data == 128'h0)
    else $error("register above limit read nonzero");
  flags_res_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE15]
    1'b1 |=> (flags_rd & ~FLAGS_MASK) == 32'h0) else $error("flags reserved bits set");
  flags_map_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE12]
    flags_we && !cc_upd.valid && !pred_we |=> ##1
      flags_rd[15:12] == $past(flags_wdata[15:12], 2)) else $error("flags cc mismatch");
  cc_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE8]
    cc_upd.valid && !cc_upd.is_float && cc_upd.result == 32'h0 |=> cc_q[CC_ZERO])
    else $error("zero flag not set");
  cc_sign_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE9]
    cc_upd.valid && cc_upd.result[31] |=> cc_q[CC_SIGN]) else $error("sign flag not set");
  cc_carry_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE10]
    cc_upd.valid && !cc_upd.is_add |=> !cc_q[CC_CARRY] && !cc_q[CC_OVFL])
    else $error("carry or overflow outside add");
  clock_run_a: assert property (@(posedge aclk) disable iff (!aresetn)  // see [RULE13]
    sreg_idx == SREG_CLOCK ##1 sreg_idx == SREG_CLOCK |=> sreg_rd == $past(sreg_rd) + 32'h1)
    else $error("clock register not counting");

endmodule : trf_top

/* dv/trf_pipe_model.sv */
/*
  Execution pipeline model: drives the operand, predicate, condition-code,
  flags and special-register ports of the thread register file.
  Assumes aclk is the core clock; calls come from the bench, one at a time.
*/
`timescale 1ns/1ps
module trf_pipe_model (
  input  wire logic                 aclk,
  input  wire logic [127:0]         rd_data,
  input  wire logic                 pred_rd,
  input  wire logic [31:0]          sreg_rd,
  output logic [5:0]                rd_idx,
  output trf_pkg::trf_width_t       rd_width,
  output trf_pkg::trf_gpr_wr_t      gpr_wr,
  output logic                      pred_we,
  output logic [2:0]                pred_idx,
  output logic                      pred_wdata,
  output logic [2:0]                pred_rd_idx,
  output trf_pkg::trf_cc_upd_t      cc_upd,
  output logic                      flags_we,
  output logic [31:0]               flags_wdata,
  output logic [6:0]                sreg_idx,
  output logic [4:0]                lane_id
);
  import trf_pkg::*;

  // Idle values at time zero
  initial begin
    rd_idx = '0; rd_width = TRF_W32; gpr_wr = '0; pred_we = 0; pred_idx = '0;
    pred_wdata = 0; pred_rd_idx = '0; cc_upd = '0; flags_we = 0; flags_wdata = '0;
    sreg_idx = '0; lane_id = '0;
  end

  // Write one grouped operand; released lines do not keep the last value
  task automatic gpr_w(input trf_width_t w, input logic [5:0] i, input logic [127:0] d);
    @(posedge aclk);
    gpr_wr <= '{en: 1'b1, width: w, idx: i, data: d};
    @(posedge aclk);
    gpr_wr <= '{en: 1'b0, width: w, idx: ~i, data: ~d};
  endtask : gpr_w

  // Read an operand, answer one cycle later
  task automatic gpr_r(input trf_width_t w, input logic [5:0] i, output logic [127:0] q);
    @(posedge aclk);
    rd_width <= w;
    rd_idx   <= i;
    @(posedge aclk);
    #1 q = rd_data;
  endtask : gpr_r

  // Write and read a predicate
  task automatic pred_w(input logic [2:0] i, input logic v);
    @(posedge aclk);
    pred_we <= 1'b1; pred_idx <= i; pred_wdata <= v;
    @(posedge aclk);
    pred_we <= 1'b0; pred_wdata <= ~v;
  endtask : pred_w
  task automatic pred_r(input logic [2:0] i, output logic q);
    @(posedge aclk);
    pred_rd_idx <= i;
    @(posedge aclk);
    #1 q = pred_rd;
  endtask : pred_r

  // Hand over one result for flag evaluation
  task automatic cc_w(input logic [3:0] fac, input logic [31:0] r);
    @(posedge aclk);
    cc_upd <= '{valid: 1'b1, is_float: fac[3], is_add: fac[2], carry: fac[1], ovfl: fac[0],
                result: r};
    @(posedge aclk);
    cc_upd <= '{valid: 1'b0, is_float: 1'b0, is_add: 1'b0, carry: 1'b0, ovfl: 1'b0, result: ~r};
  endtask : cc_w

  // Restore predicates and condition code in one move
  task automatic flags_w(input logic [31:0] d);
    @(posedge aclk);
    flags_we <= 1'b1; flags_wdata <= d;
    @(posedge aclk);
    flags_we <= 1'b0; flags_wdata <= ~d;
  endtask : flags_w

  // Special register read
  task automatic sreg_r(input logic [6:0] i, input logic [4:0] l, output logic [31:0] q);
    @(posedge aclk);
    sreg_idx <= i; lane_id <= l;
    @(posedge aclk);
    #1 q = sreg_rd;
  endtask : sreg_r
endmodule : trf_pipe_model

/* dv/trf_bench.sv */
/*
  Self-checking bench of the thread register file: AXI4-Lite master tasks,
  pipeline model calls and expected values.
  Assumes trf_pkg and trf_top are compiled first.
*/
`timescale 1ns/1ps
module trf_bench;
  import trf_pkg::*;
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pred_we, pred_wdata, pred_rd, flags_we;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, flags_wdata, flags_rd, sreg_rd, q32, q2;
  logic [3:0] s_wstrb, cc_q_out;
  logic [1:0] s_bresp, s_rresp;
  logic [5:0] rd_idx;
  logic [2:0] pred_idx, pred_rd_idx;
  logic [6:0] sreg_idx;
  logic [4:0] lane_id;
  logic [127:0] rd_data, q;
  logic qb;
  trf_width_t rd_width;
  trf_gpr_wr_t gpr_wr;
  trf_cc_upd_t cc_upd;
  int err_count, checked;
  // Flag cases: {float, add, carry, ovfl}, result, expected code
  localparam logic [39:0] CCT [0:7] = '{{4'h0, 32'h00000000, 4'h1}, {4'h0, 32'h80000001, 4'h2},
    {4'h6, 32'h00000001, 4'h4}, {4'h5, 32'h80000000, 4'ha}, {4'h8, 32'h7fc00000, 4'h3},
    {4'h8, 32'hc0000000, 4'h2}, {4'h8, 32'h00000000, 4'h1}, {4'h8, 32'h3f800000, 4'h0}};

  trf_top i_trf_top (.*);
  trf_pipe_model i_trf_pipe_model (.*);

  // Core clock, 8 ns
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // AXI4-Lite write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
    forever begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
      if (s_bvalid) break;
    end
    s_bready <= 0;
    chk(s_bresp, er);
  endtask : axi_wr

  // AXI4-Lite read
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 0;
      if (s_rvalid) break;
    end
    s_rready <= 0;
    chk(s_rresp, er);
    chk(s_rdata, ed);
  endtask : axi_rd

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    err_count = 0; checked = 0; aresetn = 0; s_awvalid = 0; s_wvalid = 0; s_bready = 0;
    s_arvalid = 0; s_rready = 0; s_awaddr = '0; s_araddr = '0; s_wdata = '0; s_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    // Single words at both ends and the zero register
    for (int k = 0; k < 3; k++) begin
      rd_tmp: begin
        logic [5:0] ix;
        ix = (k == 0) ? 6'h00 : (k == 1) ? 6'h3e : GPR_ZERO_IDX;
        i_trf_pipe_model.gpr_w(TRF_W32, ix, {96'h0, 26'h2a5a5a5, ix});
        i_trf_pipe_model.gpr_r(TRF_W32, ix, q);
        chk(q[31:0], (k == 2) ? 32'h0 : {26'h2a5a5a5, ix});
      end
    end
    // Pair and quad grouping
    i_trf_pipe_model.gpr_w(TRF_W64, 6'h04, {64'h0, 32'hbbbb0005, 32'haaaa0004});
    i_trf_pipe_model.gpr_r(TRF_W32, 6'h05, q);
    chk(q[31:0], 32'hbbbb0005);
    i_trf_pipe_model.gpr_r(TRF_W64, 6'h04, q);
    chk(q[63:0], 64'hbbbb0005_aaaa0004);
    i_trf_pipe_model.gpr_w(TRF_W128, 6'h08, 128'hc3c30000_c2c20000_c1c10000_c0c00000);
    for (int k = 0; k < 4; k++) begin
      i_trf_pipe_model.gpr_r(TRF_W32, 6'(8 + k), q);
      chk(q[31:0], {8'hc0 + 8'(k), 8'hc0 + 8'(k), 16'h0});
    end
    i_trf_pipe_model.gpr_r(TRF_W128, 6'h08, q);
    chk(q, 128'hc3c30000_c2c20000_c1c10000_c0c00000);
    // Predicates and the constant-true one
    i_trf_pipe_model.pred_w(3'h3, 1'b1);
    i_trf_pipe_model.pred_w(PRED_TRUE_IDX, 1'b0);
    i_trf_pipe_model.pred_r(PRED_TRUE_IDX, qb);
    chk(qb, 1'b1);
    i_trf_pipe_model.pred_r(3'h3, qb);
    chk(qb, 1'b1);
    i_trf_pipe_model.pred_r(3'h2, qb);
    chk(qb, 1'b0);
    // Condition code for every flag source
    for (int k = 0; k < 8; k++) begin
      i_trf_pipe_model.cc_w(CCT[k][39:36], CCT[k][35:4]);
      @(posedge aclk);
      #1 chk(cc_q_out, CCT[k][3:0]);
    end
    // Flags view restore and readback
    i_trf_pipe_model.flags_w(32'hffffffff);
    @(posedge aclk);
    #1 chk(flags_rd, 32'h0000f07f);
    chk(cc_q_out, 4'hf);
    i_trf_pipe_model.flags_w(32'h00005005);
    @(posedge aclk);
    #1 chk(flags_rd, 32'h00005005);
    i_trf_pipe_model.pred_r(3'h6, qb);
    chk(qb, 1'b0);
    axi_rd(REG_STATUS, 32'h00005005, RESP_OKAY);
    // Usable register count per program type
    i_trf_pipe_model.gpr_w(TRF_W32, 6'h0f, 128'h0f);
    i_trf_pipe_model.gpr_w(TRF_W32, 6'h10, 128'h10);
    axi_wr(REG_LIMIT0, 32'h10, RESP_OKAY);
    axi_wr(REG_PTYPE, 32'h0, RESP_OKAY);
    i_trf_pipe_model.gpr_r(TRF_W32, 6'h0f, q);
    chk(q[31:0], 32'h0f);
    i_trf_pipe_model.gpr_r(TRF_W32, 6'h10, q);
    chk(q[31:0], 32'h0);
    i_trf_pipe_model.gpr_r(TRF_W32, 6'h3e, q);
    chk(q[31:0], 32'h0);
    axi_wr(REG_LIMIT0 + 8'h04, 32'h11, RESP_OKAY);
    axi_wr(REG_PTYPE, 32'h1, RESP_OKAY);
    i_trf_pipe_model.gpr_r(TRF_W32, 6'h10, q);
    chk(q[31:0], 32'h10);
    axi_rd(REG_LIMIT0 + 8'h04, 32'h11, RESP_OKAY);
    axi_rd(8'h80, 32'h0, RESP_SLVERR);
    axi_wr(8'h80, 32'h1, RESP_SLVERR);
    // Special registers
    axi_wr(REG_TID, 32'h123, RESP_OKAY);
    axi_wr(REG_CTAID, 32'h456, RESP_OKAY);
    i_trf_pipe_model.sreg_r(SREG_TID, 5'h0b, q32);
    chk(q32, 32'h123);
    i_trf_pipe_model.sreg_r(SREG_CTAID, 5'h0b, q32);
    chk(q32, 32'h456);
    i_trf_pipe_model.sreg_r(SREG_LANEID, 5'h0b, q32);
    chk(q32, 32'h0b);
    i_trf_pipe_model.sreg_r(7'h7f, 5'h0b, q32);
    chk(q32, 32'h0);
    // Back-to-back reads sample the free-running counter two cycles apart
    i_trf_pipe_model.sreg_r(SREG_CLOCK, 5'h0b, q32);
    i_trf_pipe_model.sreg_r(SREG_CLOCK, 5'h0b, q2);
    chk(q2 - q32, 32'h2);
    give_verdict();
  end
endmodule : trf_bench
